// File: pwec_map.vh
// pwec_map.vh: register indices, field positions, reset values and timing figures
// of the pulse width / line-to-line capture block.
// assumes: included by bare name from the design files, definitions only.
`ifndef PWEC_MAP_VH
`define PWEC_MAP_VH

// per-line register indices (line chosen by the line select port)
`define PWEC_IDX_FEATURE_ENABLE     5'h00
`define PWEC_IDX_FEATURE_SELECT     5'h01
`define PWEC_IDX_CLOCK_OPTIONS      5'h02
`define PWEC_IDX_MODE_CONFIG_FIRST  5'h03
`define PWEC_IDX_HIGH_TICKS         5'h04
`define PWEC_IDX_LOW_TICKS          5'h05
`define PWEC_IDX_HIGH_SECONDS       5'h06
`define PWEC_IDX_LOW_SECONDS        5'h07
`define PWEC_IDX_HIGH_TICKS_RC      5'h08
`define PWEC_IDX_HIGH_SECONDS_RC    5'h09
// shared register indices (line select ignored)
`define PWEC_IDX_STREAM_CAPTURE     5'h0a
`define PWEC_IDX_CLK_DIVISOR_BASE   5'h0c
`define PWEC_IDX_CLK_WRAP_BASE      5'h10
`define PWEC_IDX_CLK_ENABLE_BASE    5'h14

// feature numbers
`define PWEC_FEAT_PULSE_WIDTH       32'h0000_0005
`define PWEC_FEAT_LINE_TO_LINE      32'h0000_0006

// field positions
`define PWEC_OPT_CLK_MSB            2
`define PWEC_CFG_CONTINUOUS_BIT     1
`define PWEC_CFG_EDGE_RISING_BIT    0

// clock source codes
`define PWEC_CLK_ZERO               3'h0
`define PWEC_CLK_ONE                3'h1
`define PWEC_CLK_TWO                3'h2

// reset values and stream split point
`define PWEC_RST_WORD               32'h0000_0000
`define PWEC_RST_DIVISOR            9'h000
`define PWEC_STREAM_HALF            16

// timing figures
`define PWEC_CORE_RATE_HZ           80000000
`define PWEC_SYS_RATE_HZ            125000000

`endif

// File: pwec_tick.v
// pwec_tick.v: one divided tick clock with a wrapping 32-bit tick counter.
// assumes: single clock sys_clk_i, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "pwec_map.vh"

module pwec_tick (
  input  wire        sys_clk_i,
  input  wire        srst_i,
  input  wire        enable_i,
  input  wire [8:0]  divisor_i,
  input  wire [31:0] wrap_i,
  output reg  [31:0] count_o
);

  reg  [8:0] pre_reg;
  wire [8:0] div_eff;
  wire       tick_en;

  // a divisor of zero counts as one
  assign div_eff = (divisor_i == 9'h000) ? 9'h001 : divisor_i;
  assign tick_en = enable_i && (pre_reg >= div_eff - 9'h001);

  // prescaler gives one enable pulse per divisor cycles; counter wraps at the wrap value
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      pre_reg <= 9'h000;
      count_o <= 32'h0000_0000;
    end else if (!enable_i) begin
      pre_reg <= 9'h000;
    end else if (tick_en) begin
      pre_reg <= 9'h000;
      if (wrap_i != 32'h0000_0000 && count_o >= wrap_i - 32'h0000_0001) begin
        count_o <= 32'h0000_0000;
      end else begin
        count_o <= count_o + 32'h0000_0001;
      end
    end else begin
      pre_reg <= pre_reg + 9'h001;
    end
  end

endmodule
`default_nettype wire

// File: pwec_top.v
// pwec_top.v: pulse width and line-to-line edge interval capture on two input lines.
// assumes: input lines and register port synchronous to sys_clk_i; one read or write
// per cycle; read data appears one cycle after the read strobe.
// Function
// - options bits 2..0 pick tick clock zero/one/two
// - config bit one: continuous or single measurement
// - enable field on/off; feature five is pulse width
// - high read returns ticks, latches matching low
// - low capture changes only on high reads
// - only high reads start a new measurement
// - store durations after full period, each rise
// - read-clear returns value then clears result
// - single mode measures once, waits for read
// - stream reads return low half, capture upper
// - no update operations on running measurement
// - tick rate is core rate over divisor; code divides sys_clk_i (sys rate) instead
// - divisors 1..511, zero acts as one
// - longest interval is wrap value, zero full
// - count ticks between edges on two lines
// - line-to-line is single-shot, holds result
// - config bit zero: falling or rising edge
// - interval reads zero until done, both lines
// - interval read-clear clears and restarts
`timescale 1ns/1ps
`default_nettype none
`include "pwec_map.vh"

module pwec_top (
  input  wire        sys_clk_i,
  input  wire        srst_i,
  input  wire [1:0]  sig_line_i,
  input  wire        stream_mode_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire        reg_line_i,
  input  wire [4:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  output reg  [31:0] reg_rdata_o,
  output reg         reg_rvalid_o
);

  integer i;

  // configuration storage
  reg  [1:0]  enable_reg;
  reg  [31:0] select_reg   [0:1];
  reg  [31:0] options_reg  [0:1];
  reg  [31:0] config_reg   [0:1];
  reg  [8:0]  divisor_reg  [0:2];
  reg  [31:0] wrap_reg     [0:2];
  reg  [2:0]  clk_en_reg;
  // pulse width state per line
  reg  [1:0]  seen_rise_reg;
  reg  [1:0]  seen_fall_reg;
  reg  [1:0]  halt_reg;
  reg  [31:0] rise_t_reg   [0:1];
  reg  [31:0] fall_t_reg   [0:1];
  reg  [31:0] high_reg     [0:1];
  reg  [31:0] low_pend_reg [0:1];
  reg  [31:0] low_cap_reg  [0:1];
  // line-to-line state
  reg         l2l_first_reg;
  reg         l2l_armed_reg;
  reg         l2l_got_reg;
  reg  [31:0] l2l_start_reg;
  reg  [31:0] l2l_res_reg;
  // shared
  reg  [15:0] stream_cap_reg;
  reg  [1:0]  prev_reg;

  wire [95:0] cnt_bus;
  wire [63:0] stamp_bus;
  wire [63:0] wrap_bus;
  wire [17:0] div_bus;
  wire [1:0]  rise;
  wire [1:0]  fall;
  wire [1:0]  edge_hit;
  wire [1:0]  pw_on;
  wire [1:0]  l2l_sel;
  wire        l2l_on;
  wire        sec_line;

  // wrapped difference of two tick stamps
  function [31:0] wrap_diff;
    input [31:0] t_from;
    input [31:0] t_to;
    input [31:0] wrap;
    begin
      if (wrap == 32'h0000_0000 || t_to >= t_from) begin
        wrap_diff = t_to - t_from;
      end else begin
        wrap_diff = t_to + wrap - t_from;
      end
    end
  endfunction

  // tick clocks and per-line clock source selection
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_clk
      pwec_tick u_tick (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .enable_i  (clk_en_reg[g]),
        .divisor_i (divisor_reg[g]),
        .wrap_i    (wrap_reg[g]),
        .count_o   (cnt_bus[g*32 +: 32])
      );
    end
    for (g = 0; g < 2; g = g + 1) begin : gen_line
      wire [1:0] csel;
      // reserved source codes fall back to clock zero
      assign csel = (options_reg[g][`PWEC_OPT_CLK_MSB:0] == `PWEC_CLK_ONE) ? 2'h1 :
                    (options_reg[g][`PWEC_OPT_CLK_MSB:0] == `PWEC_CLK_TWO) ? 2'h2 :
                    2'h0;
      assign stamp_bus[g*32 +: 32] = cnt_bus[csel*32 +: 32];
      assign wrap_bus[g*32 +: 32]  = wrap_reg[csel];
      assign div_bus[g*9 +: 9]     = (divisor_reg[csel] == 9'h000) ? 9'h001 : divisor_reg[csel];
      assign rise[g] = sig_line_i[g] && !prev_reg[g];
      assign fall[g] = !sig_line_i[g] && prev_reg[g];
      assign edge_hit[g] = config_reg[g][`PWEC_CFG_EDGE_RISING_BIT] ? rise[g] : fall[g];
      assign pw_on[g]   = enable_reg[g] && (select_reg[g] == `PWEC_FEAT_PULSE_WIDTH);
      assign l2l_sel[g] = enable_reg[g] && (select_reg[g] == `PWEC_FEAT_LINE_TO_LINE);
    end
  endgenerate

  assign l2l_on   = l2l_sel[0] && l2l_sel[1];
  assign sec_line = !l2l_first_reg;

  // read decode
  wire       is_high_rd = reg_rd_i && (reg_addr_i == `PWEC_IDX_HIGH_TICKS ||
                          reg_addr_i == `PWEC_IDX_HIGH_SECONDS ||
                          reg_addr_i == `PWEC_IDX_HIGH_TICKS_RC ||
                          reg_addr_i == `PWEC_IDX_HIGH_SECONDS_RC);
  wire       is_rc_rd   = reg_rd_i && (reg_addr_i == `PWEC_IDX_HIGH_TICKS_RC ||
                          reg_addr_i == `PWEC_IDX_HIGH_SECONDS_RC);
  wire       is_int_rd  = (reg_addr_i == `PWEC_IDX_HIGH_TICKS ||
                           reg_addr_i == `PWEC_IDX_LOW_TICKS ||
                           reg_addr_i == `PWEC_IDX_HIGH_TICKS_RC);
  wire [8:0] rd_div     = reg_line_i ? div_bus[17:9] : div_bus[8:0];

  // read data selection; seconds registers hold ticks scaled to undivided sys_clk_i periods
  reg  [31:0] rd_val;
  reg  [31:0] high_val;
  reg  [40:0] scaled;
  always @* begin
    rd_val   = 32'h0000_0000;
    high_val = l2l_sel[reg_line_i] ? l2l_res_reg : high_reg[reg_line_i];
    scaled   = 41'h000_0000_0000;
    case (reg_addr_i)
      `PWEC_IDX_FEATURE_ENABLE:    rd_val = {31'h0000_0000, enable_reg[reg_line_i]};
      `PWEC_IDX_FEATURE_SELECT:    rd_val = select_reg[reg_line_i];
      `PWEC_IDX_CLOCK_OPTIONS:     rd_val = options_reg[reg_line_i];
      `PWEC_IDX_MODE_CONFIG_FIRST: rd_val = config_reg[reg_line_i];
      `PWEC_IDX_HIGH_TICKS,
      `PWEC_IDX_HIGH_TICKS_RC:     rd_val = high_val;
      `PWEC_IDX_LOW_TICKS:         rd_val = low_cap_reg[reg_line_i];
      `PWEC_IDX_HIGH_SECONDS,
      `PWEC_IDX_HIGH_SECONDS_RC: begin
        scaled = high_val * rd_div;
        rd_val = scaled[31:0];
      end
      `PWEC_IDX_LOW_SECONDS: begin
        scaled = low_cap_reg[reg_line_i] * rd_div;
        rd_val = scaled[31:0];
      end
      `PWEC_IDX_STREAM_CAPTURE:    rd_val = {16'h0000, stream_cap_reg};
      `PWEC_IDX_CLK_DIVISOR_BASE:  rd_val = {23'h000000, divisor_reg[0]};
      5'h0d:                       rd_val = {23'h000000, divisor_reg[1]};
      5'h0e:                       rd_val = {23'h000000, divisor_reg[2]};
      `PWEC_IDX_CLK_WRAP_BASE:     rd_val = wrap_reg[0];
      5'h11:                       rd_val = wrap_reg[1];
      5'h12:                       rd_val = wrap_reg[2];
      `PWEC_IDX_CLK_ENABLE_BASE:   rd_val = {31'h0000_0000, clk_en_reg[0]};
      5'h15:                       rd_val = {31'h0000_0000, clk_en_reg[1]};
      5'h16:                       rd_val = {31'h0000_0000, clk_en_reg[2]};
      default:                     rd_val = 32'h0000_0000;
    endcase
  end

  // register port answer and stream capture
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o    <= 32'h0000_0000;
      reg_rvalid_o   <= 1'b0;
      stream_cap_reg <= 16'h0000;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        if (stream_mode_i && is_int_rd) begin
          reg_rdata_o    <= {16'h0000, rd_val[`PWEC_STREAM_HALF-1:0]};
          stream_cap_reg <= rd_val[31:`PWEC_STREAM_HALF];
        end else begin
          reg_rdata_o <= rd_val;
        end
      end
    end
  end

  // configuration, pulse width and line-to-line engines
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      enable_reg    <= 2'b00;
      seen_rise_reg <= 2'b00;
      seen_fall_reg <= 2'b00;
      halt_reg      <= 2'b00;
      clk_en_reg    <= 3'b000;
      prev_reg      <= 2'b00;
      l2l_first_reg <= 1'b0;
      l2l_armed_reg <= 1'b0;
      l2l_got_reg   <= 1'b0;
      l2l_start_reg <= `PWEC_RST_WORD;
      l2l_res_reg   <= `PWEC_RST_WORD;
      for (i = 0; i < 3; i = i + 1) begin
        divisor_reg[i] <= `PWEC_RST_DIVISOR;
        wrap_reg[i]    <= `PWEC_RST_WORD;
      end
      for (i = 0; i < 2; i = i + 1) begin
        select_reg[i]   <= `PWEC_RST_WORD;
        options_reg[i]  <= `PWEC_RST_WORD;
        config_reg[i]   <= `PWEC_RST_WORD;
        rise_t_reg[i]   <= `PWEC_RST_WORD;
        fall_t_reg[i]   <= `PWEC_RST_WORD;
        high_reg[i]     <= `PWEC_RST_WORD;
        low_pend_reg[i] <= `PWEC_RST_WORD;
        low_cap_reg[i]  <= `PWEC_RST_WORD;
      end
    end else begin
      prev_reg <= sig_line_i;
      // shared tick clock setup
      if (reg_wr_i) begin
        for (i = 0; i < 3; i = i + 1) begin
          if (reg_addr_i == `PWEC_IDX_CLK_DIVISOR_BASE + i[4:0]) begin
            divisor_reg[i] <= reg_wdata_i[8:0];
          end
          if (reg_addr_i == `PWEC_IDX_CLK_WRAP_BASE + i[4:0]) begin
            wrap_reg[i] <= reg_wdata_i;
          end
          if (reg_addr_i == `PWEC_IDX_CLK_ENABLE_BASE + i[4:0]) begin
            clk_en_reg[i] <= reg_wdata_i[0];
          end
        end
      end
      for (i = 0; i < 2; i = i + 1) begin
        // host reads of this line; results are never written by the host
        if (is_high_rd && reg_line_i == i[0]) begin
          low_cap_reg[i] <= low_pend_reg[i];
          if (halt_reg[i]) begin
            halt_reg[i]      <= 1'b0;
            seen_rise_reg[i] <= 1'b0;
            seen_fall_reg[i] <= 1'b0;
          end
          if (is_rc_rd) begin
            high_reg[i] <= `PWEC_RST_WORD;
          end
        end
        // pulse width edges; a store in the cycle of a clear wins
        if (pw_on[i] && !halt_reg[i]) begin
          if (rise[i]) begin
            if (seen_fall_reg[i]) begin
              high_reg[i]     <= wrap_diff(rise_t_reg[i], fall_t_reg[i],
                                           wrap_bus[i*32 +: 32]);
              low_pend_reg[i] <= wrap_diff(fall_t_reg[i], stamp_bus[i*32 +: 32],
                                           wrap_bus[i*32 +: 32]);
              halt_reg[i]     <= !config_reg[i][`PWEC_CFG_CONTINUOUS_BIT];
            end
            rise_t_reg[i]    <= stamp_bus[i*32 +: 32];
            seen_rise_reg[i] <= 1'b1;
            seen_fall_reg[i] <= 1'b0;
          end else if (fall[i] && seen_rise_reg[i]) begin
            fall_t_reg[i]    <= stamp_bus[i*32 +: 32];
            seen_fall_reg[i] <= 1'b1;
          end
        end
        // writes to the per-line enable register restart this line; results only via reads
        if (reg_wr_i && reg_line_i == i[0]) begin
          case (reg_addr_i)
            `PWEC_IDX_FEATURE_ENABLE: begin
              enable_reg[i]    <= reg_wdata_i[0];
              seen_rise_reg[i] <= 1'b0;
              seen_fall_reg[i] <= 1'b0;
              halt_reg[i]      <= 1'b0;
              high_reg[i]      <= `PWEC_RST_WORD;
              low_pend_reg[i]  <= `PWEC_RST_WORD;
            end
            `PWEC_IDX_FEATURE_SELECT:    select_reg[i]  <= reg_wdata_i;
            `PWEC_IDX_CLOCK_OPTIONS:     options_reg[i] <= reg_wdata_i;
            `PWEC_IDX_MODE_CONFIG_FIRST: config_reg[i]  <= reg_wdata_i;
            default: ;
          endcase
        end
      end
      // restart on read-clear of the interval; a completing edge below still wins
      if (is_rc_rd && l2l_sel[reg_line_i]) begin
        l2l_res_reg   <= `PWEC_RST_WORD;
        l2l_armed_reg <= 1'b1;
        l2l_got_reg   <= 1'b0;
      end
      // line-to-line: first line's edge stamps, second line's edge completes
      if (l2l_on && l2l_armed_reg) begin
        if (!l2l_got_reg && edge_hit[l2l_first_reg]) begin
          l2l_start_reg <= stamp_bus[l2l_first_reg*32 +: 32];
          l2l_got_reg   <= 1'b1;
        end else if (l2l_got_reg && edge_hit[sec_line]) begin
          l2l_res_reg   <= wrap_diff(l2l_start_reg, stamp_bus[l2l_first_reg*32 +: 32],
                                     wrap_bus[l2l_first_reg*32 +: 32]);
          l2l_armed_reg <= 1'b0;
        end
      end
      // enabling a line as line-to-line restarts; first enabled line waits first
      if (reg_wr_i && reg_addr_i == `PWEC_IDX_FEATURE_ENABLE && reg_wdata_i[0] &&
          select_reg[reg_line_i] == `PWEC_FEAT_LINE_TO_LINE) begin
        if (!l2l_sel[!reg_line_i]) begin
          l2l_first_reg <= reg_line_i;
        end
        l2l_res_reg   <= `PWEC_RST_WORD;
        l2l_armed_reg <= 1'b1;
        l2l_got_reg   <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// File: pwec_properties.sv
// pwec_properties.sv: port-level timing and result checks of the capture block
// assumes: bound to pwec_top, single clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module pwec_properties (
  input wire logic        sys_clk_i,
  input wire logic        srst_i,
  input wire logic [1:0]  sig_line_i,
  input wire logic        stream_mode_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_line_i,
  input wire logic [4:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        reg_rvalid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  logic [1:0] chg0_reg;
  logic       chg1_reg;
  // edges seen on each line since reset, saturating
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      chg0_reg <= 2'h0;
      chg1_reg <= 1'b0;
    end else begin
      if ($changed(sig_line_i[0]) && chg0_reg != 2'h3)
        chg0_reg <= chg0_reg + 2'h1;
      if ($changed(sig_line_i[1]))
        chg1_reg <= 1'b1;
    end
  end
  rvalid_follows_read_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read gave no data valid");
  rvalid_has_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("data valid without read");
  rdata_holds_a: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
    else $error("read data moved without read");
  stream_low_half_a: assert property (reg_rd_i && stream_mode_i &&
    (reg_addr_i == 5'h04 || reg_addr_i == 5'h05 || reg_addr_i == 5'h08)
    |=> reg_rdata_o[31:16] == 16'h0) else $error("stream read upper half not zero");
  clear_reads_zero_a: assert property (
    (reg_rd_i && reg_addr_i == 5'h08 && $stable(sig_line_i) &&
     sig_line_i == $past(sig_line_i, 2)) ##1
    (reg_rd_i && reg_addr_i == 5'h04 && $stable(reg_line_i) && $stable(sig_line_i))
    |=> reg_rdata_o == 32'h0) else $error("result not cleared by read clear");
  low_capture_stable_a: assert property (
    (reg_rd_i && reg_addr_i == 5'h05) ##1
    (reg_rd_i && reg_addr_i == 5'h05 && $stable(reg_line_i))
    |=> $stable(reg_rdata_o)) else $error("low capture moved without high read");
  low_write_ignored_a: assert property (
    (reg_rd_i && reg_addr_i == 5'h05) ##1
    (reg_wr_i && reg_addr_i == 5'h05 && $stable(reg_line_i)) ##1
    (reg_rd_i && reg_addr_i == 5'h05 && $stable(reg_line_i))
    |=> reg_rdata_o == $past(reg_rdata_o, 2)) else $error("write changed a result");
  empty_reads_zero_a: assert property (
    reg_rd_i && reg_addr_i == 5'h04 && !reg_line_i && chg0_reg != 2'h3 && !chg1_reg
    |=> reg_rdata_o == 32'h0) else $error("result before any full period");
  cover property (reg_rd_i && reg_addr_i == 5'h08);
  cover property (reg_rd_i && stream_mode_i);
  cover property (chg0_reg == 2'h3 && chg1_reg);
endmodule
bind pwec_top pwec_properties u_props (
  .sys_clk_i     (sys_clk_i),
  .srst_i        (srst_i),
  .sig_line_i    (sig_line_i),
  .stream_mode_i (stream_mode_i),
  .reg_wr_i      (reg_wr_i),
  .reg_rd_i      (reg_rd_i),
  .reg_line_i    (reg_line_i),
  .reg_addr_i    (reg_addr_i),
  .reg_wdata_i   (reg_wdata_i),
  .reg_rdata_o   (reg_rdata_o),
  .reg_rvalid_o  (reg_rvalid_o)
);
`default_nettype wire

// File: pwec_src_model.sv
// pwec_src_model.sv: signal source driving the two measured input lines
// assumes: lines start low, every edge lands just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module pwec_src_model (
  input  wire logic       sys_clk_i,
  output var  logic [1:0] line_o
);
  initial line_o = 2'h0;
  // idle for n clock edges
  task automatic gap(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // toggle one line just after an edge
  task automatic flip(input int ln);
    @(posedge sys_clk_i);
    line_o[ln] <= ~line_o[ln];
  endtask
  // rise, high h cycles, fall, low l cycles, rise, then back low
  task automatic pulse(input int ln, input int h, input int l);
    flip(ln);
    gap(h - 1);
    flip(ln);
    gap(l - 1);
    flip(ln);
    gap(4);
    flip(ln);
    gap(4);
  endtask
endmodule
`default_nettype wire

// File: test_pulse_width_and_edge_interval_capture.sv
// test_pulse_width_and_edge_interval_capture.sv: self-checking bench of pwec_top
// assumes: pwec_src_model drives the lines, pwec_properties is bound to the dut
`timescale 1ns/1ps
`default_nettype none
`include "pwec_map.vh"
module test_pulse_width_and_edge_interval_capture;
  typedef struct {logic ln; logic [31:0] opt; logic [31:0] cfg; int h; int l;
                  logic [31:0] eh; logic [31:0] el; logic [31:0] els;} pwec_row_t;
  logic        sys_clk_i;
  logic        srst_i;
  logic        stream_mode_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic        reg_line_i;
  logic [4:0]  reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic [1:0]  sig_line_i;
  logic [31:0] reg_rdata_o;
  logic        reg_rvalid_o;
  logic [31:0] got;
  logic [31:0] got2;
  int          mismatches    = 0;
  int          total_checks  = 0;
  // line, clock code, config, high, low, expected high, low, low seconds
  pwec_row_t rows [3] = '{'{1'b0, 32'h0, 32'h2, 5, 7, 32'h5, 32'h7, 32'h7},
                          '{1'b1, 32'h1, 32'h0, 8, 12, 32'h4, 32'h6, 32'hc},
                          '{1'b0, 32'h2, 32'h2, 8, 4, 32'h2, 32'h1, 32'h4}};
  initial sys_clk_i = 1'b0;
  always #4 sys_clk_i = ~sys_clk_i;
  pwec_top dut (
    .sys_clk_i     (sys_clk_i),
    .srst_i        (srst_i),
    .sig_line_i    (sig_line_i),
    .stream_mode_i (stream_mode_i),
    .reg_wr_i      (reg_wr_i),
    .reg_rd_i      (reg_rd_i),
    .reg_line_i    (reg_line_i),
    .reg_addr_i    (reg_addr_i),
    .reg_wdata_i   (reg_wdata_i),
    .reg_rdata_o   (reg_rdata_o),
    .reg_rvalid_o  (reg_rvalid_o)
  );
  pwec_src_model src (
    .sys_clk_i (sys_clk_i),
    .line_o    (sig_line_i)
  );
  // count and report one comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one register request, launched just after an edge
  task automatic op(input logic w, input logic r, input logic ln, input logic [4:0] a,
                    input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i    <= w;
    reg_rd_i    <= r;
    reg_line_i  <= ln;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
  endtask
  task automatic wr(input logic ln, input logic [4:0] a, input logic [31:0] d);
    op(1, 0, ln, a, d);
    op(0, 0, ln, a, d);
  endtask
  // bounded wait for data valid, then take the data
  task automatic take(output logic [31:0] q);
    int n;
    n = 0;
    #1;
    while (reg_rvalid_o !== 1'b1 && n < 4) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    q = reg_rdata_o;
    if (n == 4) begin
      chk("data valid", 32'h1, 32'h0);
      stop_test();
    end
  endtask
  task automatic rd(input logic ln, input logic [4:0] a, output logic [31:0] q);
    op(0, 1, ln, a, 32'h0);
    op(0, 0, ln, a, 32'h0);
    take(q);
  endtask
  // two reads on consecutive cycles
  task automatic rd2(input logic ln, input logic [4:0] a, input logic [4:0] b,
                     output logic [31:0] q, output logic [31:0] p);
    op(0, 1, ln, a, 32'h0);
    op(0, 1, ln, b, 32'h0);
    take(q);
    op(0, 0, ln, b, 32'h0);
    take(p);
  endtask
  task automatic setup(input logic ln, input logic [31:0] ft, input logic [31:0] opt,
                       input logic [31:0] cfg);
    wr(ln, `PWEC_IDX_FEATURE_ENABLE, 32'h0);
    wr(ln, `PWEC_IDX_FEATURE_SELECT, ft);
    wr(ln, `PWEC_IDX_CLOCK_OPTIONS, opt);
    wr(ln, `PWEC_IDX_MODE_CONFIG_FIRST, cfg);
    wr(ln, `PWEC_IDX_FEATURE_ENABLE, 32'h1);
  endtask
  // main sequence
  initial begin
    srst_i        <= 1'b1;
    stream_mode_i <= 1'b0;
    reg_wr_i      <= 1'b0;
    reg_rd_i      <= 1'b0;
    reg_line_i    <= 1'b0;
    reg_addr_i    <= 5'h00;
    reg_wdata_i   <= 32'h0000_0000;
    repeat (16) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd(0, `PWEC_IDX_FEATURE_ENABLE, got);
    chk("enable reset", 32'h0, got);
    rd(0, `PWEC_IDX_HIGH_TICKS, got);
    chk("high before period", 32'h0, got);
    rd(1, 5'h1f, got);
    chk("unmapped read", 32'h0, got);
    wr(0, 5'h0d, 32'h2);
    wr(0, 5'h0e, 32'h4);
    for (int c = 0; c < 3; c++)
      wr(0, 5'h14 + 5'(c), 32'h1);
    foreach (rows[i]) begin
      setup(rows[i].ln, `PWEC_FEAT_PULSE_WIDTH, rows[i].opt, rows[i].cfg);
      src.pulse(rows[i].ln, rows[i].h, rows[i].l);
      rd(rows[i].ln, `PWEC_IDX_HIGH_TICKS, got);
      chk("high ticks", rows[i].eh, got);
      rd(rows[i].ln, `PWEC_IDX_LOW_TICKS, got);
      chk("low ticks", rows[i].el, got);
      rd(rows[i].ln, `PWEC_IDX_LOW_SECONDS, got);
      chk("low seconds", rows[i].els, got);
    end
    src.pulse(1, 4, 4);
    src.pulse(1, 10, 10);
    rd(1, `PWEC_IDX_HIGH_TICKS, got);
    chk("single keeps first", 32'h2, got);
    src.pulse(0, 12, 8);
    rd2(0, `PWEC_IDX_HIGH_TICKS_RC, `PWEC_IDX_HIGH_TICKS, got, got2);
    chk("read clear value", 32'h3, got);
    chk("after clear", 32'h0, got2);
    src.pulse(0, 16, 4);
    rd(0, `PWEC_IDX_HIGH_SECONDS_RC, got);
    chk("seconds read clear", 32'h10, got);
    rd(0, `PWEC_IDX_HIGH_SECONDS, got);
    chk("seconds after clear", 32'h0, got);
    // low capture against repeated reads and a write
    op(0, 1, 0, 5'h05, 32'h0);
    op(0, 1, 0, 5'h05, 32'h0);
    op(1, 0, 0, 5'h05, 32'hffff);
    op(0, 1, 0, 5'h05, 32'h0);
    op(0, 0, 0, 5'h05, 32'h0);
    setup(0, `PWEC_FEAT_PULSE_WIDTH, 32'h0, 32'h2);
    @(posedge sys_clk_i);
    stream_mode_i <= 1'b1;
    src.pulse(0, 65541, 3);
    rd(0, `PWEC_IDX_HIGH_TICKS, got);
    chk("stream low half", 32'h5, got);
    rd(0, `PWEC_IDX_STREAM_CAPTURE, got);
    chk("stream upper half", 32'h1, got);
    @(posedge sys_clk_i);
    stream_mode_i <= 1'b0;
    wr(1, `PWEC_IDX_FEATURE_ENABLE, 32'h0);
    setup(0, `PWEC_FEAT_LINE_TO_LINE, 32'h0, 32'h0);
    setup(1, `PWEC_FEAT_LINE_TO_LINE, 32'h0, 32'h1);
    rd(1, `PWEC_IDX_HIGH_TICKS, got);
    chk("interval before edges", 32'h0, got);
    src.flip(1);
    src.flip(0);
    src.flip(0);
    src.flip(1);
    src.gap(5);
    src.flip(1);
    src.flip(0);
    src.flip(0);
    src.flip(1);
    src.flip(1);
    rd(0, `PWEC_IDX_HIGH_TICKS, got);
    chk("interval held", 32'h7, got);
    rd(1, `PWEC_IDX_HIGH_SECONDS, got);
    chk("interval other line", 32'h7, got);
    rd2(0, `PWEC_IDX_HIGH_TICKS_RC, `PWEC_IDX_HIGH_TICKS, got, got2);
    chk("interval read clear", 32'h7, got);
    chk("interval cleared", 32'h0, got2);
    src.flip(0);
    src.flip(0);
    src.gap(3);
    src.flip(1);
    src.flip(1);
    rd(0, `PWEC_IDX_HIGH_TICKS, got);
    chk("interval rearmed", 32'h5, got);
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd(0, `PWEC_IDX_FEATURE_SELECT, got);
    chk("select after reset", 32'h0, got);
    rd(0, `PWEC_IDX_HIGH_TICKS, got);
    chk("result after reset", 32'h0, got);
    stop_test();
  end
endmodule
`default_nettype wire
